/* design/swire_slave.v */
// slave command layer of a single-wire thermocouple converter
// Functional notes
// - low over 480us resets, abandons transaction
// - reset, selection, function; else stay silent
// - eight-bit selection command decoded after presence
// - 33h sends whole 64-bit identity code
// - 55h compares 64 bits; mismatch waits reset
// - CCh selects without identity code
// - 44h runs one conversion, then idles
// - external power: read slots show conversion status
// - BEh shifts scratchpad LSB of byte0 first
// - reset aborts scratchpad readout, starts initialisation
// - crc over bytes 0-7 sent as byte8
// - B4h: parasite pulls low, external releases
// - master starts all slots except presence
// - idle high; unlimited gap between bits
// - initialisation is reset then presence
// - presence after 15-60us wait, 60-240us low
// - write slot sampled 15-60us after fall
// - read zero held low 30us, then released
// - all bytes least significant bit first
`timescale 1ns/100ps
`default_nettype none
`include "swire_consts.vh"
module swire_slave #(
	parameter [63:0] ID_CODE    = 64'h5A00_0000_1234_5601, // arbitrary value
	parameter [16:0] RESET_CYC  = `SW_RESET_CYC,
	parameter [16:0] PWAIT_CYC  = `SW_PWAIT_CYC,
	parameter [16:0] PLOW_CYC   = `SW_PLOW_CYC,
	parameter [16:0] SAMPLE_CYC = `SW_SAMPLE_CYC,
	parameter [16:0] HOLD_CYC   = `SW_HOLD_CYC
) (
	input  wire       clock_i,
	input  wire       reset_i,
	input  wire       dq_i,
	output wire       dq_o,
	output wire       dq_oe_o,
	input  wire       parasite_i,
	output wire       convert_start_o,
	input  wire       convert_done_i,
	input  wire [7:0] scratch_data_i,
	input  wire       scratch_valid_i,
	output wire       scratch_ready_o
);
	localparam [3:0] ST_SILENT  = 4'h0;
	localparam [3:0] ST_RST_LOW = 4'h1;
	localparam [3:0] ST_PWAIT   = 4'h2;
	localparam [3:0] ST_PLOW    = 4'h3;
	localparam [3:0] ST_ROM_CMD = 4'h4;
	localparam [3:0] ST_READ_ID = 4'h5;
	localparam [3:0] ST_MATCH   = 4'h6;
	localparam [3:0] ST_SEARCH  = 4'h7;
	localparam [3:0] ST_FUNC    = 4'h8;
	localparam [3:0] ST_CONV    = 4'h9;
	localparam [3:0] ST_READ_SP = 4'hA;
	localparam [3:0] ST_POWER   = 4'hB;
	localparam [16:0] SLOT_END  = (SAMPLE_CYC > HOLD_CYC) ? SAMPLE_CYC : HOLD_CYC;

	wire       line;
	wire       parasite;
	wire [7:0] fifo_data;
	wire       fifo_valid;

	reg [3:0]  st_q;
	reg [16:0] tim_q;
	reg [16:0] low_q;
	reg [16:0] slot_q;
	reg        act_q;
	reg        line_prev_q;
	reg        oe_q;
	reg        dq_q;
	reg [6:0]  cnt_q;
	reg [1:0]  ph_q;
	reg [7:0]  sh_q;
	reg        mok_q;
	reg [7:0]  crc_q;
	reg [7:0]  txb_q;
	reg        busy_q;
	reg        start_q;
	reg        pop_q;
	reg        fill_q;
	reg        got_q;
	reg        ld_q;

	reg        is_tx;
	reg        tx_bit;
	wire       fall;
	wire       ev;
	wire       id_bit;
	wire [7:0] cmd;
	wire       crc_fb;
	wire [7:0] crc_d;

	swire_sync u_dq_sync (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (dq_i),
		.level_o (line)
	);

	swire_sync u_pwr_sync (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.pin_i   (parasite_i),
		.level_o (parasite)
	);

	// the core only drains during a readout, so the fifo genuinely fills
	swire_fifo #(
		.WIDTH (`SW_FIFO_WIDTH),
		.DEPTH (`SW_FIFO_DEPTH),
		.AW    (`SW_FIFO_AW)
	) u_fifo (
		.clock_i     (clock_i),
		.reset_i     (reset_i),
		.in_data_i   (scratch_data_i),
		.in_valid_i  (scratch_valid_i),
		.in_ready_o  (scratch_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (pop_q)
	);

	assign fall   = line_prev_q & ~line;
	assign ev     = act_q && (slot_q == SAMPLE_CYC - 17'd1);
	assign id_bit = ID_CODE[cnt_q[5:0]];
	assign cmd    = {line, sh_q[7:1]};
	assign crc_fb = crc_q[0] ^ txb_q[0];
	assign crc_d  = (crc_q >> 1) ^ (crc_fb ? `SW_CRC_POLY : 8'h00);

	// what the current state puts on the bus in a read slot
	always @*
	begin
		is_tx  = 1'b0;
		tx_bit = 1'b1;
		case (st_q)
			ST_READ_ID:
			begin
				is_tx  = 1'b1;
				tx_bit = id_bit;
			end
			ST_SEARCH:
			begin
				is_tx  = (ph_q != 2'd2);
				tx_bit = (ph_q == 2'd0) ? id_bit : ~id_bit;
			end
			ST_CONV:
			begin
				is_tx  = 1'b1;
				tx_bit = ~busy_q;
			end
			ST_READ_SP:
			begin
				is_tx  = 1'b1;
				tx_bit = txb_q[0];
			end
			ST_POWER:
			begin
				is_tx  = 1'b1;
				tx_bit = ~parasite;
			end
			default:
			begin
				is_tx  = 1'b0;
				tx_bit = 1'b1;
			end
		endcase
	end

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_q        <= ST_SILENT;
			tim_q       <= 17'h00000;
			low_q       <= 17'h00000;
			slot_q      <= 17'h00000;
			act_q       <= 1'b0;
			line_prev_q <= 1'b1;
			oe_q        <= 1'b0;
			dq_q        <= 1'b0;
			cnt_q       <= 7'h00;
			ph_q        <= 2'h0;
			sh_q        <= 8'h00;
			mok_q       <= 1'b0;
			crc_q       <= `SW_CRC_RESET;
			txb_q       <= `SW_FILL_BYTE;
			busy_q      <= 1'b0;
			start_q     <= 1'b0;
			pop_q       <= 1'b0;
			fill_q      <= 1'b0;
			got_q       <= 1'b0;
			ld_q        <= 1'b0;
		end
		else
		begin
			line_prev_q <= line;
			dq_q        <= 1'b0;
			start_q     <= 1'b0;
			pop_q       <= 1'b0;
			ld_q        <= fill_q;
			got_q       <= pop_q;
			fill_q      <= 1'b0;
			if (ld_q)
				txb_q <= got_q ? fifo_data : `SW_FILL_BYTE;
			// a start in the same cycle as done keeps the device busy
			if (start_q)
				busy_q <= 1'b1;
			else if (convert_done_i)
				busy_q <= 1'b0;

			// our own pull-down must not look like a master reset
			if (!line && !oe_q)
			begin
				if (low_q != RESET_CYC)
					low_q <= low_q + 17'd1;
			end
			else
				low_q <= 17'h00000;

			// slot timer: a bit is written or read once per master fall
			if (act_q)
			begin
				slot_q <= slot_q + 17'd1;
				if (slot_q == HOLD_CYC - 17'd1)
					oe_q <= 1'b0;
				if (slot_q == SLOT_END - 17'd1)
					act_q <= 1'b0;
			end
			else if (fall && (st_q >= ST_ROM_CMD))
			begin
				act_q  <= 1'b1;
				slot_q <= 17'h00000;
				oe_q   <= is_tx & ~tx_bit;
			end

			case (st_q)
				ST_RST_LOW:
				begin
					if (line)
					begin
						st_q  <= ST_PWAIT;
						tim_q <= 17'h00000;
					end
				end
				ST_PWAIT:
				begin
					tim_q <= tim_q + 17'd1;
					if (tim_q == PWAIT_CYC - 17'd1)
					begin
						st_q  <= ST_PLOW;
						tim_q <= 17'h00000;
						oe_q  <= 1'b1;
					end
				end
				ST_PLOW:
				begin
					tim_q <= tim_q + 17'd1;
					if (tim_q == PLOW_CYC - 17'd1)
					begin
						oe_q  <= 1'b0;
						st_q  <= ST_ROM_CMD;
						cnt_q <= 7'h00;
					end
				end
				ST_ROM_CMD:
				begin
					if (ev)
					begin
						sh_q  <= cmd;
						cnt_q <= cnt_q + 7'd1;
						if (cnt_q == 7'd7)
						begin
							cnt_q <= 7'h00;
							ph_q  <= 2'h0;
							mok_q <= 1'b1;
							case (cmd)
								`SW_CMD_READ_ID: st_q <= ST_READ_ID;
								`SW_CMD_MATCH:   st_q <= ST_MATCH;
								`SW_CMD_SEARCH:  st_q <= ST_SEARCH;
								`SW_CMD_SKIP:    st_q <= ST_FUNC;
								default:         st_q <= ST_SILENT;
							endcase
						end
					end
				end
				ST_READ_ID:
				begin
					if (ev)
					begin
						cnt_q <= cnt_q + 7'd1;
						if (cnt_q[5:0] == `SW_ID_LAST)
						begin
							st_q  <= ST_FUNC;
							cnt_q <= 7'h00;
						end
					end
				end
				ST_MATCH:
				begin
					if (ev)
					begin
						cnt_q <= cnt_q + 7'd1;
						if (line != id_bit)
							mok_q <= 1'b0;
						if (cnt_q[5:0] == `SW_ID_LAST)
						begin
							cnt_q <= 7'h00;
							st_q  <= (mok_q && (line == id_bit)) ? ST_FUNC : ST_SILENT;
						end
					end
				end
				ST_SEARCH:
				begin
					if (ev)
					begin
						if (ph_q != 2'd2)
							ph_q <= ph_q + 2'd1;
						else if (line != id_bit)
							st_q <= ST_SILENT;
						else if (cnt_q[5:0] == `SW_ID_LAST)
							st_q <= ST_SILENT;
						else
						begin
							ph_q  <= 2'd0;
							cnt_q <= cnt_q + 7'd1;
						end
					end
				end
				ST_FUNC:
				begin
					if (ev)
					begin
						sh_q  <= cmd;
						cnt_q <= cnt_q + 7'd1;
						if (cnt_q == 7'd7)
						begin
							cnt_q <= 7'h00;
							crc_q <= `SW_CRC_RESET;
							case (cmd)
								`SW_CMD_CONVERT:
								begin
									st_q    <= ST_CONV;
									start_q <= 1'b1;
									busy_q  <= 1'b1;
								end
								`SW_CMD_READ_SP:
								begin
									st_q   <= ST_READ_SP;
									pop_q  <= fifo_valid;
									fill_q <= 1'b1;
								end
								`SW_CMD_POWER: st_q <= ST_POWER;
								default:       st_q <= ST_SILENT;
							endcase
						end
					end
				end
				ST_READ_SP:
				begin
					if (ev)
					begin
						cnt_q <= cnt_q + 7'd1;
						txb_q <= txb_q >> 1;
						if (cnt_q < `SW_SP_CRC_START + 7'd1)
							crc_q <= crc_d;
						if (cnt_q == `SW_SP_LAST)
							st_q <= ST_SILENT;
						else if (cnt_q == `SW_SP_CRC_START)
							txb_q <= crc_d;
						else if (cnt_q[2:0] == 3'd7)
						begin
							pop_q  <= fifo_valid;
							fill_q <= 1'b1;
						end
					end
				end
				ST_CONV, ST_POWER, ST_SILENT:
				begin
					st_q <= st_q;
				end
				default:
				begin
					st_q <= ST_SILENT;
				end
			endcase

			// a long low wins over everything above
			if (low_q == RESET_CYC - 17'd1)
			begin
				st_q   <= ST_RST_LOW;
				act_q  <= 1'b0;
				oe_q   <= 1'b0;
				fill_q <= 1'b0;
				pop_q  <= 1'b0;
			end
		end
	end

	assign dq_o            = dq_q;
	assign dq_oe_o         = oe_q;
	assign convert_start_o = start_q;
endmodule
`default_nettype wire

/* design/swire_consts.vh */
// constants for the single-wire slave command layer
`ifndef SWIRE_CONSTS_VH
`define SWIRE_CONSTS_VH

`define SW_CLK_MHZ        200
`define SW_T_RESET_US     480
`define SW_T_PWAIT_US     30
`define SW_T_PLOW_US      120
`define SW_T_SAMPLE_US    30
`define SW_T_HOLD_US      30

`define SW_RESET_CYC      (`SW_T_RESET_US * `SW_CLK_MHZ)
`define SW_PWAIT_CYC      (`SW_T_PWAIT_US * `SW_CLK_MHZ)
`define SW_PLOW_CYC       (`SW_T_PLOW_US * `SW_CLK_MHZ)
`define SW_SAMPLE_CYC     (`SW_T_SAMPLE_US * `SW_CLK_MHZ)
`define SW_HOLD_CYC       (`SW_T_HOLD_US * `SW_CLK_MHZ)

`define SW_CMD_SEARCH     8'hF0
`define SW_CMD_READ_ID    8'h33
`define SW_CMD_MATCH      8'h55
`define SW_CMD_SKIP       8'hCC
`define SW_CMD_CONVERT    8'h44
`define SW_CMD_READ_SP    8'hBE
`define SW_CMD_POWER      8'hB4

`define SW_CRC_POLY       8'h8C
`define SW_CRC_RESET      8'h00
`define SW_ID_LAST        6'h3F
`define SW_SP_LAST        7'h47
`define SW_SP_CRC_START   7'h3F
`define SW_FILL_BYTE      8'hFF

`define SW_FIFO_WIDTH     8
`define SW_FIFO_DEPTH     32
`define SW_FIFO_AW        5

`endif

/* design/swire_sync.v */
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module swire_sync (
	input  wire clock_i,
	input  wire reset_i,
	input  wire pin_i,
	output wire level_o
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg level_q;

	// stage one feeds only stage two
	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s1_q    <= 1'b1;
			s2_q    <= 1'b1;
			s3_q    <= 1'b1;
			level_q <= 1'b1;
		end
		else
		begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				level_q <= s3_q;
		end
	end

	assign level_o = level_q;
endmodule
`default_nettype wire

/* design/swire_fifo.v */
// byte fifo with registered read data
`timescale 1ns/100ps
`default_nettype none
module swire_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clock_i,
	input  wire             reset_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      count_q;
	reg             ready_q;
	reg [WIDTH-1:0] rdata_q;
	wire            push;
	wire            pop;
	wire [AW:0]     count_d;

	assign push    = in_valid_i & ready_q;
	assign pop     = out_ready_i & (count_q != {(AW+1){1'b0}});
	assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always @(posedge clock_i)
	begin
		if (push)
			mem[wr_q] <= in_data_i;
	end

	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			wr_q    <= {AW{1'b0}};
			rd_q    <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			ready_q <= 1'b1;
			rdata_q <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
			begin
				rd_q    <= rd_q + 1'b1;
				rdata_q <= mem[rd_q];
			end
			count_q <= count_d;
			// ready is a flop so the block output is registered
			ready_q <= (count_d != DEPTH[AW:0]) && (count_d[AW] == 1'b0);
		end
	end

	assign in_ready_o  = ready_q;
	assign out_data_o  = rdata_q;
	assign out_valid_o = (count_q != {(AW+1){1'b0}});
endmodule
`default_nettype wire

/* tb/swire_slave_checker.sv */
// concurrent checks on the pins of the single-wire slave
`timescale 1ns/100ps
`default_nettype none
module swire_slave_checker #(
	parameter [16:0] RESET_CYC = 17'd40,
	parameter [16:0] PLOW_CYC  = 17'd12
) (
	input wire logic       clock_i,
	input wire logic       reset_i,
	input wire logic       dq_i,
	input wire logic       dq_o,
	input wire logic       dq_oe_o,
	input wire logic       parasite_i,
	input wire logic       convert_start_o,
	input wire logic       convert_done_i,
	input wire logic [7:0] scratch_data_i,
	input wire logic       scratch_valid_i,
	input wire logic       scratch_ready_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);
	reg [16:0] low_q;
	reg [16:0] drv_q;
	always @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			low_q <= 17'h0;
			drv_q <= 17'h0;
		end
		else
		begin
			low_q <= dq_i ? 17'h0 : low_q + 17'h1;
			drv_q <= dq_oe_o ? drv_q + 17'h1 : 17'h0;
		end
	end
	// presence must wait a little after the rise, then come
	sequence quiet_wait;
		!dq_oe_o [*5];
	endsequence
	sequence presence_on;
		##[1:8] dq_oe_o;
	endsequence
	a_presence_time: assert property ((dq_i && low_q > RESET_CYC) |-> quiet_wait ##0 presence_on)
		else $error("presence missing or early after bus reset");
	a_low_quiet: assert property ((low_q > 17'd20) |-> !dq_oe_o)
		else $error("device drives during a long low");
	a_drive_max: assert property (drv_q <= PLOW_CYC)
		else $error("device drive too long");
	a_drive_min: assert property ($fell(dq_oe_o) |-> $past(dq_oe_o, 6))
		else $error("device drive too short");
	a_drive_start: assert property ($rose(dq_oe_o) |-> low_q < 17'd6)
		else $error("device drive not tied to a slot or presence");
	a_pull_only: assert property (dq_o == 1'b0)
		else $error("data output not low");
	a_start_single: assert property (convert_start_o |=> !convert_start_o [*3])
		else $error("conversion start not a single pulse");
	a_ready_reset: assert property ($fell(reset_i) |-> scratch_ready_o)
		else $error("fifo not ready after reset");
endmodule
bind swire_slave swire_slave_checker #(
	.RESET_CYC (RESET_CYC),
	.PLOW_CYC  (PLOW_CYC)
) chk_i (
	.clock_i         (clock_i),
	.reset_i         (reset_i),
	.dq_i            (dq_i),
	.dq_o            (dq_o),
	.dq_oe_o         (dq_oe_o),
	.parasite_i      (parasite_i),
	.convert_start_o (convert_start_o),
	.convert_done_i  (convert_done_i),
	.scratch_data_i  (scratch_data_i),
	.scratch_valid_i (scratch_valid_i),
	.scratch_ready_o (scratch_ready_o)
);
`default_nettype wire

/* tb/swire_master.sv */
// bus master model: reset, write and read slots of 16 cycles
`timescale 1ns/100ps
`default_nettype none
module swire_master (
	input  wire logic clock_i,
	input  wire logic bus_i,
	output var  logic pull_o
);
	// no strong pullup: conversion is polled only when externally powered
	initial pull_o = 1'b0;
	task automatic wait_n(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic rst(output logic p);
		pull_o = 1'b1;
		wait_n(50);
		pull_o = 1'b0;
		p = 1'b0;
		repeat (30)
		begin
			wait_n(1);
			if (bus_i === 1'b0)
				p = 1'b1;
		end
	endtask
	task automatic wb(input logic b);
		pull_o = 1'b1;
		wait_n(3);
		if (b)
			pull_o = 1'b0;
		wait_n(9);
		pull_o = 1'b0;
		wait_n(4);
	endtask
	task automatic rb(output logic b);
		pull_o = 1'b1;
		wait_n(3);
		pull_o = 1'b0;
		wait_n(6);
		b = bus_i;
		wait_n(7);
	endtask
	task automatic wbyte(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			wb(d[i]);
	endtask
	task automatic rbyte(output logic [7:0] d);
		for (int i = 0; i < 8; i++)
			rb(d[i]);
	endtask
	task automatic wid(input logic [63:0] v);
		for (int i = 0; i < 64; i++)
			wb(v[i]);
	endtask
endmodule
`default_nettype wire

/* tb/tb_swire_slave.sv */
// testbench for the single-wire slave command layer
`timescale 1ns/100ps
`default_nettype none
module tb_swire_slave;
	localparam logic [63:0] ID = 64'h5A00_0000_1234_5601; // arbitrary value
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic parasite_i = 1'b0;
	logic convert_done_i = 1'b0;
	logic [7:0] scratch_data_i = 8'h00;
	logic scratch_valid_i = 1'b0;
	wire dq_o;
	wire dq_oe_o;
	wire convert_start_o;
	wire scratch_ready_o;
	wire pull;
	wire dq_line;
	int err_total = 0;
	int compares = 0;
	int starts = 0;
	assign dq_line = ~(pull | dq_oe_o);
	always #2.5 clock_i = ~clock_i;
	always @(posedge clock_i)
		if (convert_start_o === 1'b1)
			starts++;
	swire_slave #(
		.ID_CODE    (ID),
		.RESET_CYC  (17'd40),
		.PWAIT_CYC  (17'd6),
		.PLOW_CYC   (17'd12),
		.SAMPLE_CYC (17'd6),
		.HOLD_CYC   (17'd6)
	) dut (
		.clock_i         (clock_i),
		.reset_i         (reset_i),
		.dq_i            (dq_line),
		.dq_o            (dq_o),
		.dq_oe_o         (dq_oe_o),
		.parasite_i      (parasite_i),
		.convert_start_o (convert_start_o),
		.convert_done_i  (convert_done_i),
		.scratch_data_i  (scratch_data_i),
		.scratch_valid_i (scratch_valid_i),
		.scratch_ready_o (scratch_ready_o)
	);
	swire_master m (
		.clock_i (clock_i),
		.bus_i   (dq_line),
		.pull_o  (pull)
	);
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("mismatches %0d, compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// reflected update, one data bit at a time from the lsb
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r >> 1) ^ (((r[0] ^ d[i]) == 1'b1) ? 8'h8C : 8'h00);
		return r;
	endfunction
	task automatic t_cold;
		logic [7:0] d;
		m.rbyte(d);
		chk(d, 8'hFF);
	endtask
	task automatic t_id;
		logic p;
		logic [7:0] d;
		logic [63:0] v;
		m.rst(p);
		chk(p, 1'b1);
		m.wbyte(8'h33);
		for (int i = 0; i < 8; i++)
		begin
			m.rbyte(d);
			v[8*i+:8] = d;
		end
		chk(v, ID);
	endtask
	task automatic t_order;
		logic p;
		logic b;
		int s;
		m.rst(p);
		s = starts;
		m.wbyte(8'h44);
		m.rb(b);
		chk(starts, s);
		chk(b, 1'b1);
	endtask
	task automatic t_unknown;
		logic p;
		logic [7:0] d;
		m.rst(p);
		m.wbyte(8'h00);
		m.wbyte(8'hCC);
		m.rbyte(d);
		chk(d, 8'hFF);
	endtask
	task automatic t_power;
		logic p;
		logic b;
		parasite_i = 1'b0;
		m.rst(p);
		m.wbyte(8'hCC);
		// a long idle pause between commands; the external-power read gives 1 even if the selection is lost
		repeat (300) @(posedge clock_i);
		#1;
		m.wbyte(8'hB4);
		m.rb(b);
		chk(b, 1'b1);
	endtask
	task automatic t_match;
		logic p;
		logic b;
		parasite_i = 1'b1;
		m.rst(p);
		m.wbyte(8'h55);
		m.wid(ID ^ 64'h1);
		m.wbyte(8'hB4);
		m.rb(b);
		chk(b, 1'b1);
		m.rst(p);
		m.wbyte(8'h55);
		m.wid(ID);
		m.wbyte(8'hB4);
		m.rb(b);
		chk(b, 1'b0);
	endtask
	task automatic t_conv;
		logic p;
		logic b;
		int s;
		parasite_i = 1'b0;
		m.rst(p);
		m.wbyte(8'hCC);
		s = starts;
		m.wbyte(8'h44);
		chk(starts, s + 1);
		m.rb(b);
		chk(b, 1'b0);
		@(posedge clock_i);
		#1 convert_done_i = 1'b1;
		@(posedge clock_i);
		#1 convert_done_i = 1'b0;
		m.rb(b);
		chk(b, 1'b1);
	endtask
	task automatic t_search;
		logic p;
		logic a;
		logic b;
		m.rst(p);
		m.wbyte(8'hF0);
		for (int i = 0; i < 64; i++)
		begin
			m.rb(a);
			m.rb(b);
			chk({a, b}, {ID[i], ~ID[i]});
			m.wb(ID[i]);
		end
		m.rb(a);
		chk(a, 1'b1);
		m.rst(p);
		m.wbyte(8'hF0);
		m.rb(a);
		m.rb(b);
		m.wb(~ID[0]);
		m.rb(a);
		m.rb(b);
		chk({a, b}, 2'b11);
	endtask
	task automatic t_scratch;
		logic p;
		logic b;
		logic [7:0] d;
		logic [7:0] c;
		scratch_valid_i = 1'b1;
		for (int k = 0; k < 32; k++)
		begin
			scratch_data_i = 8'h10 + 8'(k);
			chk(scratch_ready_o, 1'b1);
			@(posedge clock_i);
			#1;
		end
		// one more offer while full: must not land in the readout
		scratch_data_i = 8'hEE;
		chk(scratch_ready_o, 1'b0);
		@(posedge clock_i);
		#1 scratch_valid_i = 1'b0;
		for (int r = 0; r < 4; r++)
		begin
			m.rst(p);
			m.wbyte(8'hCC);
			m.wbyte(8'hBE);
			c = 8'h00;
			for (int j = 0; j < 8; j++)
			begin
				m.rbyte(d);
				chk(d, 8'h10 + 8'(8 * r + j));
				c = crc8(c, d);
			end
			m.rbyte(d);
			chk(d, c);
		end
		chk(scratch_ready_o, 1'b1);
		m.rst(p);
		m.wbyte(8'hCC);
		m.wbyte(8'hBE);
		m.rbyte(d);
		chk(d, 8'hFF);
		m.rb(b);
		m.rst(p);
		chk(p, 1'b1);
		parasite_i = 1'b1;
		m.wbyte(8'hCC);
		m.wbyte(8'hB4);
		m.rb(b);
		chk(b, 1'b0);
	endtask
	initial
	begin
		repeat (60000) @(posedge clock_i);
		err_total++;
		final_report();
	end
	initial
	begin
		repeat (16) @(posedge clock_i);
		#1 reset_i = 1'b0;
		t_cold();
		t_id();
		t_order();
		t_unknown();
		t_power();
		t_match();
		t_conv();
		t_search();
		t_scratch();
		final_report();
	end
endmodule
`default_nettype wire
